// ### logic/clock_sync_pkg.sv
package clock_sync_pkg;

    localparam int          REG_INDEX_W      = 12;
    localparam int          DIV_W            = 10;
    localparam int          CHANNELS         = 4;

    localparam logic [11:0] IDX_UPDATE       = 12'h0005;
    localparam logic [11:0] IDX_MF_ENABLE    = 12'h0200;
    localparam logic [11:0] IDX_MF_FUNCTION  = 12'h0201;
    localparam logic [11:0] IDX_CHARGE_PUMP  = 12'h0400;
    localparam logic [11:0] IDX_CAL_CONTROL  = 12'h0405;
    localparam logic [11:0] IDX_RF_DIVIDERS  = 12'h0407;
    localparam logic [11:0] IDX_SYNC_CONTROL = 12'h0500;
    localparam logic [11:0] IDX_OUT_ENABLE   = 12'h0501;
    localparam logic [11:0] IDX_RATIO_BASE   = 12'h0502;
    localparam logic [11:0] IDX_FRAME_ENABLE = 12'h0640;
    localparam logic [11:0] IDX_FRAME_CTRL   = 12'h0641;
    localparam logic [11:0] IDX_PIN_CONTROL  = 12'h0642;
    localparam logic [11:0] IDX_PRIORITY     = 12'h0643;
    localparam logic [11:0] IDX_LOOP_MODE    = 12'h0A01;
    localparam logic [11:0] IDX_PLL_STATUS   = 12'h0D01;

    localparam logic [7:0]  UPDATE_CODE      = 8'h01;
    localparam logic [7:0]  MF_ENABLE_CODE   = 8'h01;
    localparam logic [3:0]  RF_RESET_CODE    = 4'hF;
    localparam int          CAL_START_BIT    = 0;
    localparam int          CAL_NOGATE_BIT   = 3;
    localparam int          SYNC_DIRECT_BIT  = 2;
    localparam int          SYNC_MASK_LSB    = 4;
    localparam int          STAT_DPLL_BIT    = 0;
    localparam int          STAT_CAL_BIT     = 1;
    localparam int          STAT_OUTPUT_ANALOG_LOOP_BIT    = 2;
    localparam int          FRAME_VALID_BIT  = 3;
    localparam int          FREE_RUN_BIT     = 5;
    localparam int          HOLDOVER_BIT     = 6;

    localparam logic [1:0]  SRC_NONE         = 2'b00;
    localparam logic [1:0]  SRC_DPLL_LOCK    = 2'b01;
    localparam logic [1:0]  SRC_REF_EDGE     = 2'b10;
    localparam logic [1:0]  SRC_SYNC_PIN     = 2'b11;

    localparam logic [9:0]  RATIO_RESET      = 10'h001;
    localparam logic [7:0]  CHARGE_RESET     = 8'h00;

    localparam int          CLK_PERIOD_NS    = 50;
    localparam int          CAL_TIME_NS      = 10000;
    localparam int          CAL_CYCLES       = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_LOCK = 2'b10,
        CAL_DONE = 2'b11
    } cal_state_type;

    typedef struct packed {
        logic [7:0] charge_pump;
        logic       calibrate;
        logic [1:0] rf_div_reset;
        logic [3:0] rf_div_one;
        logic [3:0] rf_div_two;
    } analog_ctrl_type;

    typedef struct packed {
        logic select_second;
        logic holdover;
        logic steer;
        logic frame_edge;
    } ref_select_type;

endpackage

// ### logic/clock_sync_control.sv
`timescale 1ns/1ps
module clock_sync_control
    import clock_sync_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES
) (
    // Clock and reset.
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave.
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic [31:0]               hrdata,
    output logic                      hresp,
    // Asynchronous pins.
    input  wire logic [3:0]           ref_input,
    input  wire logic                 output_analog_loop_locked,
    input  wire logic                 sync_pin_n,
    input  wire logic                 mf_sync_pin,
    input  wire logic                 hard_pin_mode,
    // Same-clock status.
    input  wire logic [3:0]           ref_valid,
    input  wire logic                 dpll_locked,
    input  wire logic                 eeprom_sync_op,
    // Outputs.
    output analog_ctrl_type           analog_ctrl,
    output logic [CHANNELS-1:0]       channel_out,
    output ref_select_type            ref_select,
    output logic                      user_free_run,
    output logic                      user_holdover
);

    // Shadow copies take bus writes; active copies steer the logic.
    logic [7:0]       sh_mf_enable, ac_mf_enable;
    logic             sh_mf_route, ac_mf_route;
    logic [7:0]       sh_charge, ac_charge;
    logic [7:0]       sh_cal, ac_cal;
    logic [7:0]       sh_rf, ac_rf;
    logic [7:0]       sh_sync, ac_sync;
    logic [3:0]       sh_enable, ac_enable;
    logic [DIV_W-1:0] sh_ratio [CHANNELS];
    logic [DIV_W-1:0] ac_ratio [CHANNELS];
    logic             sh_frame_en, ac_frame_en;
    logic [3:0]       sh_frame, ac_frame;
    logic             sh_soft, ac_soft;
    logic [7:0]       sh_prio, ac_prio;
    logic [7:0]       sh_loop, ac_loop;

    logic             wr_pend;
    logic [11:0]      wr_idx;
    logic             update;
    logic             direct_sync;
    logic             auto_sync;
    logic [7:0]       pin_meta, pin_sync, pin_prev;
    logic             dpll_prev;
    cal_state_type    cal_state;
    logic [15:0]      cal_cnt;
    logic             cal_prev;
    logic             frame_active;
    logic             pair_first, pair_second;
    logic             sel_second;

    logic [31:0]      bus_word;
    logic [11:0]      a_idx;
    logic             a_ok;
    logic             wr_take;
    logic             output_analog_loop_ready;
    logic             gate_open;
    logic             sync_event;
    logic             sync_fwd;
    logic             ref_rise;

    assign a_idx   = haddr[13:2];
    assign a_ok    = hsel && hready && htrans[1] && (haddr[31:14] == 18'h0_0000)
                     && (haddr[1:0] == 2'b00);
    assign wr_take = wr_pend && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 12'h000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend <= a_ok && hwrite;
                wr_idx  <= a_idx;
            end
        end
    end

    always_comb begin
        bus_word = 32'h0000_0000;
        case (a_idx)
            IDX_MF_ENABLE:    bus_word[7:0] = sh_mf_enable;
            IDX_MF_FUNCTION:  bus_word[0]   = sh_mf_route;
            IDX_CHARGE_PUMP:  bus_word[7:0] = sh_charge;
            IDX_CAL_CONTROL:  bus_word[7:0] = sh_cal;
            IDX_RF_DIVIDERS:  bus_word[7:0] = sh_rf;
            IDX_SYNC_CONTROL: bus_word[7:0] = sh_sync;
            IDX_OUT_ENABLE:   bus_word[3:0] = sh_enable;
            IDX_FRAME_ENABLE: bus_word[0]   = sh_frame_en;
            IDX_FRAME_CTRL:   bus_word[3:0] = sh_frame;
            IDX_PIN_CONTROL:  bus_word[0]   = sh_soft;
            IDX_PRIORITY:     bus_word[7:0] = sh_prio;
            IDX_LOOP_MODE:    bus_word[7:0] = sh_loop;
            IDX_PLL_STATUS: begin
                bus_word[STAT_DPLL_BIT] = dpll_locked;
                bus_word[STAT_CAL_BIT]  = (cal_state == CAL_RUN);
                bus_word[STAT_OUTPUT_ANALOG_LOOP_BIT] = output_analog_loop_ready;
            end
            default: begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (a_idx == IDX_RATIO_BASE + 12'(i)) begin
                        bus_word[DIV_W-1:0] = sh_ratio[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (a_ok && !hwrite) begin
            hrdata <= bus_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_mf_enable <= 8'h00;
            sh_mf_route  <= 1'b0;
            sh_charge    <= CHARGE_RESET;
            sh_cal       <= 8'h00;
            sh_rf        <= 8'h00;
            sh_sync      <= 8'h00;
            sh_enable    <= 4'h0;
            sh_frame_en  <= 1'b0;
            sh_frame     <= 4'h0;
            sh_soft      <= 1'b0;
            sh_prio      <= 8'h00;
            sh_loop      <= 8'h00;
            for (int i = 0; i < CHANNELS; i++) begin
                sh_ratio[i] <= RATIO_RESET;
            end
        end else begin
            // The direct sync bit is a strobe; it clears once applied.
            if (update) begin
                sh_sync[SYNC_DIRECT_BIT] <= 1'b0;
            end
            if (wr_take) begin
                case (wr_idx)
                    IDX_MF_ENABLE:    sh_mf_enable <= hwdata[7:0];
                    IDX_MF_FUNCTION:  sh_mf_route  <= hwdata[0];
                    IDX_CHARGE_PUMP:  sh_charge    <= hwdata[7:0];
                    IDX_CAL_CONTROL:  sh_cal       <= hwdata[7:0];
                    IDX_RF_DIVIDERS:  sh_rf        <= hwdata[7:0];
                    IDX_SYNC_CONTROL: sh_sync      <= hwdata[7:0];
                    IDX_OUT_ENABLE:   sh_enable    <= hwdata[3:0];
                    IDX_FRAME_ENABLE: sh_frame_en  <= hwdata[0];
                    IDX_FRAME_CTRL:   sh_frame     <= hwdata[3:0];
                    IDX_PIN_CONTROL:  sh_soft      <= hwdata[0];
                    IDX_PRIORITY:     sh_prio      <= hwdata[7:0];
                    IDX_LOOP_MODE:    sh_loop      <= hwdata[7:0];
                    default: begin
                        for (int i = 0; i < CHANNELS; i++) begin
                            if (wr_idx == IDX_RATIO_BASE + 12'(i)) begin
                                sh_ratio[i] <= hwdata[DIV_W-1:0];
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            update       <= 1'b0;
            direct_sync  <= 1'b0;
            auto_sync    <= 1'b0;
            ac_mf_enable <= 8'h00;
            ac_mf_route  <= 1'b0;
            ac_charge    <= CHARGE_RESET;
            ac_cal       <= 8'h00;
            ac_rf        <= 8'h00;
            ac_sync      <= 8'h00;
            ac_enable    <= 4'h0;
            ac_frame_en  <= 1'b0;
            ac_frame     <= 4'h0;
            ac_soft      <= 1'b0;
            ac_prio      <= 8'h00;
            ac_loop      <= 8'h00;
            for (int i = 0; i < CHANNELS; i++) begin
                ac_ratio[i] <= RATIO_RESET;
            end
        end else begin
            update      <= wr_take && (wr_idx == IDX_UPDATE) && (hwdata[7:0] == UPDATE_CODE);
            direct_sync <= update && sh_sync[SYNC_DIRECT_BIT];
            // routing the pin before its enable applies fires a sync.
            auto_sync   <= update && sh_mf_route && !ac_mf_route
                           && (ac_mf_enable != MF_ENABLE_CODE);
            if (update) begin
                ac_mf_enable <= sh_mf_enable;
                ac_mf_route  <= sh_mf_route;
                ac_charge    <= sh_charge;
                ac_cal       <= sh_cal;
                ac_rf        <= sh_rf;
                ac_sync      <= sh_sync;
                ac_enable    <= sh_enable;
                ac_frame_en  <= sh_frame_en;
                ac_frame     <= sh_frame;
                ac_soft      <= sh_soft;
                ac_prio      <= sh_prio;
                ac_loop      <= sh_loop;
                for (int i = 0; i < CHANNELS; i++) begin
                    ac_ratio[i] <= sh_ratio[i];
                end
            end
        end
    end

    // Pins pass two flops; a third copy serves edge detection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta  <= 8'h00;
            pin_sync  <= 8'h00;
            pin_prev  <= 8'h00;
            dpll_prev <= 1'b0;
        end else begin
            pin_meta  <= {hard_pin_mode, mf_sync_pin, sync_pin_n,
                          output_analog_loop_locked, ref_input};
            pin_sync  <= pin_meta;
            pin_prev  <= pin_sync;
            dpll_prev <= dpll_locked;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_state <= CAL_IDLE;
            cal_cnt   <= 16'h0000;
            cal_prev  <= 1'b0;
        end else begin
            cal_prev <= ac_cal[CAL_START_BIT];
            case (cal_state)
                CAL_IDLE, CAL_DONE, CAL_LOCK: begin
                    if (ac_cal[CAL_START_BIT] && !cal_prev) begin
                        cal_state <= CAL_RUN;
                        cal_cnt   <= 16'h0000;
                    end else if (cal_state == CAL_LOCK && pin_sync[4]) begin
                        cal_state <= CAL_DONE;
                    end
                end
                CAL_RUN: begin
                    if (cal_cnt == 16'(CAL_COUNT - 1)) begin
                        cal_state <= CAL_LOCK;
                    end else begin
                        cal_cnt <= cal_cnt + 16'h0001;
                    end
                end
                default: cal_state <= CAL_IDLE;
            endcase
        end
    end

    assign output_analog_loop_ready = (cal_state == CAL_DONE) && pin_sync[4];
    assign gate_open  = output_analog_loop_ready || ac_cal[CAL_NOGATE_BIT];
    assign ref_rise   = sel_second ? (pin_sync[1] && !pin_prev[1])
                                   : (pin_sync[0] && !pin_prev[0]);

    always_comb begin
        sync_event = direct_sync || eeprom_sync_op || auto_sync
                     || (ac_mf_enable == MF_ENABLE_CODE && ac_mf_route
                         && pin_sync[6] && !pin_prev[6]);
        case (ac_sync[1:0])
            SRC_DPLL_LOCK: sync_event = sync_event || (dpll_locked && !dpll_prev);
            SRC_REF_EDGE:  sync_event = sync_event || ref_rise;
            // In frame mode the sync pin fires no sync and is not used.
            SRC_SYNC_PIN:  sync_event = sync_event || (!frame_active
                                        && !pin_sync[5] && pin_prev[5]);
            default:       sync_event = sync_event;
        endcase
    end

    assign sync_fwd = sync_event && gate_open;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_ctrl   <= '0;
            user_free_run <= 1'b0;
            user_holdover <= 1'b0;
        end else begin
            analog_ctrl.charge_pump  <= ac_charge;
            analog_ctrl.calibrate    <= (cal_state == CAL_RUN);
            analog_ctrl.rf_div_one   <= ac_rf[3:0];
            analog_ctrl.rf_div_two   <= ac_rf[7:4];
            analog_ctrl.rf_div_reset <= {(cal_state == CAL_RUN) || ac_rf[7:4] == RF_RESET_CODE,
                                         (cal_state == CAL_RUN) || ac_rf[3:0] == RF_RESET_CODE};
            user_free_run <= ac_loop[FREE_RUN_BIT];
            user_holdover <= ac_loop[HOLDOVER_BIT];
        end
    end

    // Each half period lasts ratio hclk cycles (ratio 0 acts as 1), so any ratio gives an even duty.
    for (genvar g = 0; g < CHANNELS; g++) begin : gen_channel
        logic [DIV_W-1:0] cnt;
        logic             phase;
        logic             running;
        logic             en_live;
        logic             mask;
        logic [DIV_W-1:0] last;

        assign mask = ac_sync[SYNC_MASK_LSB + g];
        assign last = (ac_ratio[g] == '0) ? '0 : ac_ratio[g] - 10'h001;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt            <= '0;
                phase          <= 1'b0;
                running        <= 1'b0;
                en_live        <= 1'b0;
                channel_out[g] <= 1'b0;
            end else begin
                channel_out[g] <= phase && en_live;
                if (sync_fwd && !mask) begin
                    running <= 1'b1;
                    cnt     <= '0;
                    phase   <= 1'b0;
                end else if (mask && gate_open && !running) begin
                    running <= 1'b1;
                    cnt     <= '0;
                    phase   <= 1'b0;
                end else if (running) begin
                    if (cnt >= last) begin
                        cnt   <= '0;
                        phase <= !phase;
                    end else begin
                        cnt <= cnt + 10'h001;
                    end
                end
                if (!running || (phase && cnt >= last)) begin
                    en_live <= ac_enable[g];
                end
            end
        end
    end

    assign frame_active = ac_frame_en && !ac_soft && !pin_sync[7];
    assign pair_first   = ref_valid[0] && (ref_valid[2] || !ac_frame[FRAME_VALID_BIT]);
    assign pair_second  = ref_valid[1] && (ref_valid[3] || !ac_frame[FRAME_VALID_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_second <= 1'b0;
            ref_select <= '0;
        end else begin
            if (pair_first && pair_second) begin
                sel_second <= (ac_prio[6:4] > ac_prio[2:0]);
            end else if (pair_first || pair_second) begin
                sel_second <= pair_second;
            end
            ref_select.select_second <= sel_second;
            ref_select.holdover <= frame_active && !pair_first && !pair_second;
            ref_select.steer <= frame_active && (pair_first || pair_second);
            ref_select.frame_edge <= frame_active && (pair_first || pair_second)
                && (sel_second ? (pin_sync[3] && !pin_prev[3])
                               : (pin_sync[2] && !pin_prev[2]));
        end
    end

endmodule

// ### tb/clock_sync_control_sva.sv
`timescale 1ns/1ps
module clock_sync_control_sva
    import clock_sync_pkg::*;
#(
    parameter int CAL_COUNT = CAL_CYCLES
) (
    // Bus side.
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hsel,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic [31:0]     hrdata,
    input wire logic            hresp,
    // Control side.
    input wire logic            hard_pin_mode,
    input wire analog_ctrl_type analog_ctrl,
    input wire ref_select_type  ref_select
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Length of the current calibration run, compared when it ends.
    int cal_len;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_len <= 0;
        end else if (analog_ctrl.calibrate) begin
            cal_len <= cal_len + 1;
        end else begin
            cal_len <= 0;
        end
    end

    sequence strap_held;
        hard_pin_mode [*6];
    endsequence
    sequence no_read_taken;
        !(hsel && hready && htrans[1] && !hwrite);
    endsequence

    bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    read_hold_a: assert property (no_read_taken |=> $stable(hrdata))
        else $error("read data moved without a read");
    cal_reset_a: assert property (analog_ctrl.calibrate |-> analog_ctrl.rf_div_reset == 2'b11)
        else $error("dividers not held in reset during calibration");
    cal_length_a: assert property ($fell(analog_ctrl.calibrate) |-> cal_len == CAL_COUNT)
        else $error("calibration run has wrong length");
    rf_code_a: assert property (analog_ctrl.rf_div_one == 4'hF |-> analog_ctrl.rf_div_reset[0])
        else $error("divider reset code not honoured");
    edge_steer_a: assert property (ref_select.frame_edge |-> ref_select.steer)
        else $error("frame edge without steering");
    hold_steer_a: assert property (ref_select.holdover |-> !ref_select.steer)
        else $error("steering during holdover");
    hold_keep_a: assert property (ref_select.holdover && $past(ref_select.holdover)
        |-> $stable(ref_select.select_second))
        else $error("selection changed during holdover");
    strap_off_a: assert property (strap_held |-> !ref_select.steer && !ref_select.holdover)
        else $error("frame mode active under pin control");
endmodule

bind clock_sync_control clock_sync_control_sva #(.CAL_COUNT(CAL_COUNT)) sva_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .hard_pin_mode(hard_pin_mode), .analog_ctrl(analog_ctrl), .ref_select(ref_select));

// ### tb/test_clock_sync_control.sv
`timescale 1ns/1ps
module test_clock_sync_control import clock_sync_pkg::*;;
    logic            hclk, hresetn, hwrite, hreadyout, hresp, mf_sync_pin, user_holdover;
    logic [31:0]     haddr, hwdata, hrdata, rd;
    logic [1:0]      htrans;
    logic [3:0]      ref_input, ref_valid, channel_out;
    logic            output_analog_loop_locked, hard_pin_mode, eeprom_sync_op, user_free_run;
    analog_ctrl_type analog_ctrl;
    ref_select_type  ref_select;
    logic [2:0]      sel_now;
    int              errors, checked, cycles, n;
    assign sel_now = {ref_select.select_second, ref_select.holdover, ref_select.steer};

    // A short calibration keeps the run brief; the checker gets the same value.
    clock_sync_control #(.CAL_COUNT(4)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ref_input(ref_input),
        .output_analog_loop_locked(output_analog_loop_locked), .sync_pin_n(1'b1),
        .mf_sync_pin(mf_sync_pin), .hard_pin_mode(hard_pin_mode), .ref_valid(ref_valid),
        .dpll_locked(1'b0), .eeprom_sync_op(eeprom_sync_op), .analog_ctrl(analog_ctrl),
        .channel_out(channel_out), .ref_select(ref_select), .user_free_run(user_free_run),
        .user_holdover(user_holdover));

    always #25 hclk = ~hclk;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every transfer starts just after a rising edge and waits on ready.
    task automatic xfer(input logic [31:0] addr, input logic w, input logic [31:0] data);
        @(posedge hclk);
        haddr <= addr; hwrite <= w; htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00; hwdata <= data;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] data);
        xfer({18'h0, idx, 2'b00}, 1'b1, {24'h0, data});
    endtask

    task automatic upd();
        wr(IDX_UPDATE, UPDATE_CODE);
        // Active copies load one edge after the update pulse, outputs one edge later.
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask

    task automatic span(input logic lvl);
        n = 0;
        while (channel_out[0] === lvl && n < 300) begin
            @(negedge hclk);
            n++;
        end
    endtask

    task automatic sel(input logic [2:0] exp, input logic [2:0] mask);
        n = 0;
        while ((sel_now & mask) !== exp && n < 20) begin
            @(negedge hclk);
            n++;
        end
        check("ref_select", 32'(exp), 32'(sel_now & mask));
    endtask

    task automatic refs(input logic [3:0] valid, input logic [3:0] pins);
        @(posedge hclk);
        ref_valid <= valid; ref_input <= pins;
    endtask

    task automatic test_registers();
        wr(IDX_RF_DIVIDERS, 8'h5A);
        @(negedge hclk);
        check("rf_div_one early", 32'h0, 32'(analog_ctrl.rf_div_one));
        xfer({18'h0, IDX_RF_DIVIDERS, 2'b00}, 1'b0, 32'h0);
        check("rf readback", 32'h5A, rd);
        upd();
        check("rf_div_one", 32'hA, 32'(analog_ctrl.rf_div_one));
        check("rf_div_two", 32'h5, 32'(analog_ctrl.rf_div_two));
        wr(IDX_RF_DIVIDERS, 8'h5F);
        upd();
        check("rf_div_reset", 32'h1, 32'(analog_ctrl.rf_div_reset));
        xfer(32'h0000_0400, 1'b0, 32'h0);
        check("unmapped read", 32'h0, rd);
    endtask

    task automatic test_gate();
        wr(IDX_RATIO_BASE, 8'h03);
        wr(IDX_RATIO_BASE + 12'h001, 8'h03);
        wr(IDX_OUT_ENABLE, 8'h0F);
        wr(IDX_SYNC_CONTROL, 8'h84);
        upd();
        span(1'b0);
        check("gated sync", 32'd300, 32'(n));
    endtask

    task automatic test_calibration();
        @(posedge hclk);
        output_analog_loop_locked <= 1'b1;
        wr(IDX_LOOP_MODE, 8'h60);
        wr(IDX_CAL_CONTROL, 8'h20);
        upd();
        check("free run", 32'h1, 32'(user_free_run));
        check("holdover", 32'h1, 32'(user_holdover));
        wr(IDX_CAL_CONTROL, 8'h21);
        upd();
        for (n = 0; n < 10 && analog_ctrl.calibrate !== 1'b1; n++) @(negedge hclk);
        check("cal rf reset", 32'h3, 32'(analog_ctrl.rf_div_reset));
        rd = 32'h0;
        for (n = 0; n < 20 && rd[STAT_OUTPUT_ANALOG_LOOP_BIT] !== 1'b1; n++)
            xfer({18'h0, IDX_PLL_STATUS, 2'b00}, 1'b0, 32'h0);
        check("loop status", 32'h1, 32'(rd[STAT_OUTPUT_ANALOG_LOOP_BIT]));
        // The masked channel has ratio 1, so it toggles on every cycle once started.
        @(negedge hclk);
        rd[0] = channel_out[3];
        @(negedge hclk);
        check("masked start", 32'(!rd[0]), 32'(channel_out[3]));
    endtask

    task automatic test_pin_sync();
        wr(IDX_MF_ENABLE, MF_ENABLE_CODE);
        upd();
        wr(IDX_MF_FUNCTION, 8'h01);
        upd();
        // Without a restart channel 0 would be high here; a restart holds it low.
        @(posedge hclk);
        mf_sync_pin <= 1'b1;
        repeat (5) @(negedge hclk);
        span(1'b0);
        check("pin sync restart", 32'd3, 32'(n));
    endtask

    task automatic test_sync();
        @(posedge hclk);
        eeprom_sync_op <= 1'b1;
        @(posedge hclk);
        eeprom_sync_op <= 1'b0;
        span(1'b0);
        span(1'b1);
        span(1'b0);
        check("low span", 32'd3, 32'(n));
        span(1'b1);
        check("high span", 32'd3, 32'(n));
        check("unison", 32'(channel_out[0]), 32'(channel_out[1]));
    endtask

    task automatic test_frame();
        wr(IDX_PRIORITY, 8'h51);
        wr(IDX_FRAME_CTRL, 8'h08);
        wr(IDX_FRAME_ENABLE, 8'h01);
        upd();
        refs(4'b0111, 4'h0);
        sel(3'b001, 3'b111);
        refs(4'b1111, 4'h0);
        sel(3'b101, 3'b111);
        refs(4'b1111, 4'h8);
        for (n = 0; n < 10 && ref_select.frame_edge !== 1'b1; n++) @(negedge hclk);
        check("frame edge", 32'h1, 32'(ref_select.frame_edge));
        refs(4'b0000, 4'h0);
        sel(3'b110, 3'b111);
        @(posedge hclk);
        hard_pin_mode <= 1'b1;
        sel(3'b000, 3'b011);
    endtask

    initial begin
        hclk = 1'b0; hresetn = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hwdata = 32'h0; ref_input = 4'h0; ref_valid = 4'h0; hard_pin_mode = 1'b0;
        output_analog_loop_locked = 1'b0; eeprom_sync_op = 1'b0; mf_sync_pin = 1'b0;
        errors = 0; checked = 0; cycles = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_registers();
        test_gate();
        test_calibration();
        test_sync();
        test_pin_sync();
        test_frame();
        complete_run();
    end
endmodule
